/* File: bench/ftc_array_model.sv */
`timescale 1ns/1ns
module ftc_array_model import ftc_pkg::*; (
	input wire logic mclk,
	input wire logic fa_rd,
	input wire logic fa_prog,
	input wire logic fa_erase,
	input wire ftc_erg_t fa_region,
	input wire logic fa_info,
	input wire logic [16:0] fa_addr,
	input wire logic [15:0] fa_wdata,
	input wire logic lock,
	input wire logic stuck,
	output logic [15:0] fa_rdata
);
	logic [15:0] mem [logic [17:0]];
	logic [15:0] prot_w = ERASED_WORD;
	logic [15:0] last = 16'h0000;
	logic [15:0] word;
	logic pg_d = 1'b0;
	logic er_d = 1'b0;
	////////////////////////////////////////
	// array contents, erased cells read all ones
	always @(negedge mclk or fa_info or fa_addr or prot_w) begin
		if (fa_info && fa_addr == PROT_WORD_ADDR)
			word = prot_w;
		else if (mem.exists({fa_info, fa_addr}))
			word = mem[{fa_info, fa_addr}];
		else
			word = ERASED_WORD;
	end
	// released data lines keep changing
	assign fa_rdata = !fa_rd ? ~last : (stuck ? ~word : word);
	always @(posedge mclk) begin
		last <= fa_rdata;
		pg_d <= fa_prog;
		er_d <= fa_erase;
		if (lock)
			prot_w <= 16'hfffc;
		if (fa_prog && !pg_d)
			mem[{fa_info, fa_addr}] = word & fa_wdata;
		if (fa_erase && !er_d) begin
			mem.delete();
			if (fa_region == ERG_PROT)
				prot_w <= ERASED_WORD;
		end
	end
endmodule : ftc_array_model

/* File: bench/ftc_ctrl_tb.sv */
`timescale 1ns/1ns
module ftc_ctrl_tb import ftc_pkg::*;;
	localparam logic [8:0][7:0] ROW10 = {8'h05, 8'h3e, 8'h19, 8'h0c, 8'h0c,
		8'h0c, 8'h32, 8'h19, 8'h01};
	logic mclk = 1'b0, sys_rst = 1'b1, soft_rst = 1'b0, clk_stable = 1'b0;
	logic jtag_en = 1'b0, prog_en = 1'b0, page_erase_en = 1'b0;
	logic section_erase_en = 1'b0, verify_en = 1'b0, tim_wr = 1'b0;
	logic cb_rd = 1'b0, cb_wr = 1'b0, cb_host = 1'b0, cb_info = 1'b0;
	logic jt_req = 1'b0, jt_info = 1'b0, lock = 1'b0, stuck = 1'b0;
	logic [2:0] zone_wait_config = 3'h0;
	logic [3:0] tim_sel = 4'h0;
	logic [7:0] tim_wdata = 8'h00;
	logic [16:0] cb_addr = 17'h00000, jt_addr = 17'h00000, fa_addr;
	logic [15:0] cb_wdata = 16'h0000, jt_wdata = 16'h0000;
	logic [15:0] rd_data, fa_rdata, fa_wdata;
	ftc_op_t jt_op = OP_READ;
	ftc_erg_t fa_region;
	logic cb_ack, cb_retry, jt_busy, busy, err_prog, err_erase, prot_active;
	logic core_hold_rst, rst_ext, fa_rd, fa_prog, fa_erase, fa_info;
	logic erase_d = 1'b0, rty;
	ftc_erg_t regions[$];
	int err_total = 0, comparisons = 0, cyc_total = 0, ack_cnt = 0, k, n;

	ftc_ctrl ftc_ctrl_inst (.mclk, .sys_rst, .soft_rst, .clk_stable, .jtag_en,
		.prog_en, .page_erase_en, .section_erase_en, .verify_en,
		.zone_wait_config, .tim_wr, .tim_sel, .tim_wdata, .cb_rd, .cb_wr,
		.cb_host, .cb_info, .cb_addr, .cb_wdata, .cb_ack, .cb_retry, .jt_req,
		.jt_op, .jt_info, .jt_addr, .jt_wdata, .jt_busy, .rd_data, .busy,
		.err_prog, .err_erase, .prot_active, .core_hold_rst, .rst_ext, .fa_rd,
		.fa_prog, .fa_erase, .fa_region, .fa_info, .fa_addr, .fa_wdata,
		.fa_rdata);
	ftc_array_model ftc_array_model_inst (.mclk, .fa_rd, .fa_prog, .fa_erase,
		.fa_region, .fa_info, .fa_addr, .fa_wdata, .lock, .stuck, .fa_rdata);

	initial begin
		forever #5 mclk = ~mclk;
	end
	// erase region log, ack count, hang guard
	always @(posedge mclk) begin
		erase_d <= fa_erase;
		if (fa_erase === 1'b1 && erase_d !== 1'b1)
			regions.push_back(fa_region);
		if (cb_ack === 1'b1)
			ack_cnt++;
		cyc_total++;
		if (cyc_total == 20000) begin
			err_total++;
			wrap_up();
		end
	end
	////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic wrap_up;
		if (err_total == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : wrap_up
	function automatic logic near(input int v, input int e);
		return v >= e - 3 && v <= e + 3;
	endfunction : near
	function automatic int op_len(input logic [8:0][7:0] r, input int pl,
			input int en, input logic vf);
		int p;
		p = int'(r[IX_PRESCALE][2:0]) + 1;
		return (int'(r[IX_START]) + int'(r[pl]) + int'(r[en]) +
			int'(r[IX_RCV])) * p + (vf ? 11 : 8);
	endfunction : op_len
	task automatic bus(input logic wr, input logic host, input logic info,
			input logic [16:0] a, input logic [15:0] d, input int lim,
			output int c, output logic r);
		@(negedge mclk);
		cb_rd = !wr;
		cb_wr = wr;
		cb_host = host;
		cb_info = info;
		cb_addr = a;
		cb_wdata = d;
		c = 0;
		do begin
			@(posedge mclk);
			c++;
			#1;
		end while (cb_ack !== 1'b1 && c < lim);
		r = cb_retry;
		if (cb_ack !== 1'b1)
			c = 0;
		@(negedge mclk);
		cb_rd = 1'b0;
		cb_wr = 1'b0;
	endtask : bus
	task automatic wait_low(input logic jt, output int c);
		c = 0;
		do begin
			@(posedge mclk);
			c++;
			#1;
		end while ((jt ? jt_busy : busy) === 1'b1 && c < 3000);
		@(negedge mclk);
	endtask : wait_low
	task automatic op(input logic info, input logic [16:0] a, output int c);
		bus(1'b1, 1'b0, info, a, 16'h5a0f, 20, k, rty);
		wait_low(1'b0, c);
	endtask : op
	task automatic jt_cmd(input ftc_op_t o, input logic [16:0] a);
		@(negedge mclk);
		jt_req = 1'b1;
		jt_op = o;
		jt_addr = a;
		@(negedge mclk);
		jt_req = 1'b0;
		@(negedge mclk);
	endtask : jt_cmd
	////////////////////////////////////////
	task automatic t_read;
		bus(1'b0, 1'b0, 1'b0, 17'h00010, 16'h0000, 20, k, rty);
		check(k, 0);
		clk_stable = 1'b1;
		repeat (12) @(negedge mclk);
		for (int i = 0; i < 8; i++) begin
			zone_wait_config = 3'(i);
			bus(1'b0, 1'b0, 1'b0, 17'(i), 16'h0000, 20, k, rty);
			check(k, i + 3);
			check(rd_data, ERASED_WORD);
		end
		bus(1'b0, 1'b0, 1'b1, 17'h00004, 16'h0000, 20, k, rty);
		check(k, INFO_RD_CYCLES + 1);
		check(busy, 1'b0);
	endtask : t_read
	task automatic t_prog;
		prog_en = 1'b1;
		verify_en = 1'b1;
		bus(1'b1, 1'b0, 1'b0, 17'h00100, 16'ha5c3, 20, k, rty);
		check(k, 1);
		check(busy, 1'b1);
		bus(1'b0, 1'b1, 1'b0, 17'h00100, 16'h0000, 20, k, rty);
		check(rty, 1'b1);
		bus(1'b1, 1'b0, 1'b0, 17'h00100, 16'h0000, 20, k, rty);
		prog_en = 1'b0;
		bus(1'b0, 1'b0, 1'b0, 17'h00100, 16'h0000, 300, k, rty);
		check(busy, 1'b0);
		check(rd_data, 16'ha5c3);
		check(err_prog, 1'b0);
		prog_en = 1'b1;
		op(1'b0, 17'h00200, n);
		check(near(n, op_len(TIM_DEFAULTS, IX_PROG, IX_END, 1'b1)), 1'b1);
		prog_en = 1'b0;
	endtask : t_prog
	task automatic t_timing;
		for (int i = 0; i < TIM_NUM; i++) begin
			@(negedge mclk);
			tim_wr = 1'b1;
			tim_sel = 4'(i);
			tim_wdata = ROW10[i];
		end
		@(negedge mclk);
		tim_wr = 1'b0;
		page_erase_en = 1'b1;
		verify_en = 1'b0;
		stuck = 1'b1;
		op(1'b0, 17'h00200, n);
		check(near(n, op_len(ROW10, IX_PERASE, IX_END, 1'b0)), 1'b1);
		check(err_erase, 1'b0);
		verify_en = 1'b1;
		op(1'b0, 17'h00200, n);
		check(err_erase, 1'b1);
		page_erase_en = 1'b0;
		prog_en = 1'b1;
		stuck = 1'b0;
		bus(1'b1, 1'b0, 1'b0, 17'h00300, 16'h1234, 20, k, rty);
		soft_rst = 1'b1;
		repeat (3) @(negedge mclk);
		check(busy, 1'b1);
		check(rst_ext, 1'b1);
		soft_rst = 1'b0;
		wait_low(1'b0, n);
		check(near(n + 3, op_len(ROW10, IX_PROG, IX_END, 1'b1)), 1'b1);
		repeat (12) @(negedge mclk);
		check(rst_ext, 1'b0);
		stuck = 1'b1;
		op(1'b0, 17'h00400, n);
		check(near(n, op_len(TIM_DEFAULTS, IX_PROG, IX_END, 1'b1)), 1'b1);
		check(err_prog, 1'b1);
		prog_en = 1'b0;
		stuck = 1'b0;
	endtask : t_timing
	task automatic t_section;
		section_erase_en = 1'b1;
		bus(1'b1, 1'b1, 1'b0, 17'h00500, 16'h0000, 20, k, rty);
		@(negedge mclk);
		check(busy, 1'b0);
		verify_en = 1'b0;
		stuck = 1'b1;
		regions.delete();
		op(1'b0, 17'h00500, n);
		check(err_erase, 1'b1);
		stuck = 1'b0;
		op(1'b1, 17'h00090, n);
		check(err_erase, 1'b0);
		check(regions.size(), 2);
		check(regions[0], ERG_SECT_MAIN);
		check(regions[1], ERG_SECT_BOTH);
		section_erase_en = 1'b0;
	endtask : t_section
	task automatic t_abort;
		n = ack_cnt;
		@(negedge mclk);
		cb_rd = 1'b1;
		cb_addr = 17'h00020;
		repeat (3) @(negedge mclk);
		check(fa_rd, 1'b1);
		soft_rst = 1'b1;
		cb_rd = 1'b0;
		repeat (2) @(negedge mclk);
		check(fa_rd, 1'b0);
		soft_rst = 1'b0;
		repeat (12) @(negedge mclk);
		check(ack_cnt, n);
	endtask : t_abort
	task automatic t_jtag;
		lock = 1'b1;
		@(negedge mclk);
		lock = 1'b0;
		jtag_en = 1'b1;
		repeat (12) @(negedge mclk);
		check(core_hold_rst, 1'b1);
		check(prot_active, 1'b1);
		jt_cmd(OP_PROG, 17'h00100);
		check(jt_busy, 1'b0);
		regions.delete();
		jt_cmd(OP_SPERASE, 17'h00000);
		soft_rst = 1'b1;
		repeat (4) @(negedge mclk);
		check(jt_busy, 1'b1);
		soft_rst = 1'b0;
		wait_low(1'b1, n);
		check(regions.size(), 3);
		check(regions[0], ERG_ALL_MAIN);
		check(regions[1], ERG_INFO_NOFACT);
		check(regions[2], ERG_PROT);
		check(err_erase, 1'b0);
		jtag_en = 1'b0;
		repeat (12) @(negedge mclk);
		check(core_hold_rst, 1'b0);
		check(prot_active, 1'b0);
		jtag_en = 1'b1;
		repeat (12) @(negedge mclk);
		regions.delete();
		jt_cmd(OP_PERASE, 17'h00100);
		wait_low(1'b1, n);
		jt_info = 1'b1;
		jt_cmd(OP_SERASE, 17'h00090);
		wait_low(1'b1, n);
		check(regions.size(), 2);
		check(regions[0], ERG_PAGE);
		check(regions[1], ERG_SECT_BOTH);
		jt_info = 1'b0;
		jt_wdata = 16'h3c3c;
		jt_cmd(OP_PROG, 17'h00180);
		check(busy, 1'b1);
		wait_low(1'b1, n);
		check(err_prog, 1'b0);
		jt_cmd(OP_READ, 17'h00100);
		check(jt_busy, 1'b1);
		wait_low(1'b1, n);
		check(rd_data, ERASED_WORD);
	endtask : t_jtag
	////////////////////////////////////////
	initial begin
		repeat (12) @(posedge mclk);
		@(negedge mclk);
		sys_rst = 1'b0;
		t_read();
		t_prog();
		t_timing();
		t_section();
		t_abort();
		t_jtag();
		wrap_up();
	end
endmodule : ftc_ctrl_tb

/* File: inc/ftc_if.sv */
`timescale 1ns/1ns
interface ftc_if;
	logic tmr_start;
	logic [7:0] tmr_count;
	logic [2:0] tmr_prescale;
	logic tmr_done;
	logic ini_go;
	logic ini_clk_ok;
	logic ini_prot_rd;
	logic ini_load;
	logic ini_ready;
	modport ctl(output tmr_start, tmr_count, tmr_prescale, ini_go, ini_clk_ok,
		input tmr_done, ini_prot_rd, ini_load, ini_ready);
	modport tmr(input tmr_start, tmr_count, tmr_prescale, output tmr_done);
	modport ini(input ini_go, ini_clk_ok,
		output ini_prot_rd, ini_load, ini_ready);
endinterface : ftc_if

/* File: inc/ftc_pkg.sv */
package ftc_pkg;

////////////////////////////////////////////////////////////////////////////////
// timing register slots
localparam int IX_PRESCALE = 0;
localparam int IX_START = 1;
localparam int IX_TRAN = 2;
localparam int IX_PROG = 3;
localparam int IX_PERASE = 4;
localparam int IX_SERASE = 5;
localparam int IX_END = 6;
localparam int IX_SEND = 7;
localparam int IX_RCV = 8;
localparam int TIM_NUM = 9;

////////////////////////////////////////////////////////////////////////////////
// power-up defaults, 4 mhz core clock
localparam logic [7:0] DEF_PRESCALE = 8'h00;
localparam logic [7:0] DEF_START = 8'h14;
localparam logic [7:0] DEF_TRAN = 8'h28;
localparam logic [7:0] DEF_PROG = 8'h0a;
localparam logic [7:0] DEF_PERASE = 8'h09;
localparam logic [7:0] DEF_SERASE = 8'h09;
localparam logic [7:0] DEF_END = 8'h14;
localparam logic [7:0] DEF_SEND = 8'h32;
localparam logic [7:0] DEF_RCV = 8'h04;
localparam logic [8:0][7:0] TIM_DEFAULTS = {DEF_RCV, DEF_SEND, DEF_END,
	DEF_SERASE, DEF_PERASE, DEF_PROG, DEF_TRAN, DEF_START, DEF_PRESCALE};

////////////////////////////////////////////////////////////////////////////////
// read timing and array constants
localparam logic [7:0] INFO_RD_CYCLES = 8'h03;
localparam logic [7:0] MAIN_RD_BASE = 8'h02;
localparam logic [16:0] PROT_WORD_ADDR = 17'h000fe;
localparam logic [15:0] ERASED_WORD = 16'hffff;
localparam int PROT_LSB = 0;
localparam logic [1:0] PROT_OPEN = 2'h3;

////////////////////////////////////////////////////////////////////////////////
// enumerations
typedef enum logic [2:0] {ERG_PAGE, ERG_SECT_MAIN, ERG_SECT_BOTH,
	ERG_ALL_MAIN, ERG_INFO_NOFACT, ERG_PROT} ftc_erg_t;
typedef enum logic [2:0] {OP_READ, OP_PROG, OP_PERASE, OP_SERASE,
	OP_SPERASE} ftc_op_t;
typedef enum logic [2:0] {ST_STANDBY, ST_READ, ST_PROG, ST_PERASE,
	ST_SERASE, ST_SPERASE} ftc_st_t;
typedef enum logic [2:0] {PH_START, PH_PULSE, PH_END, PH_RCV, PH_TRAN,
	PH_VERIFY} ftc_ph_t;
typedef enum logic [1:0] {SRC_CORE, SRC_HOST, SRC_JTAG} ftc_src_t;

endpackage : ftc_pkg

/* File: src/ftc_ctrl.sv */
// Functional notes
// - six states, pulse widths from timing registers
// - standby when idle, after ops, after reset
// - main bus reads stretched by zone; jtag busy
// - program on write with bit set, busy
// - program verify updates err_prog if enabled
// - program ignores reset and writes, holds reads
// - page erase on write or jtag, busy
// - section erase core or jtag, never host
// - info section erase also erases main section
// - special erase jtag only, allowed when protected
// - special erase busy, verify, protection last
// - no flash access during program or erase
// - jtag mode holds core in reset, bus accesses not served
// - info timing internal, main read by zone
// - timing registers default to 4 mhz values
// - reset during read aborts the read
// - reset during program or erase is stretched outside jtag mode, ignored in jtag mode
// - reinit after reset: clocks, protection, defaults
// - leaving jtag mode reinitialises the interface
// - host accesses get retry during program or erase, outside jtag mode
`timescale 1ns/1ns
module ftc_ctrl import ftc_pkg::*; (
	input logic mclk,
	input logic sys_rst,
	input logic soft_rst,
	input logic clk_stable,
	input logic jtag_en,
	input logic prog_en,
	input logic page_erase_en,
	input logic section_erase_en,
	input logic verify_en,
	input logic [2:0] zone_wait_config,
	input logic tim_wr,
	input logic [3:0] tim_sel,
	input logic [7:0] tim_wdata,
	input logic cb_rd,
	input logic cb_wr,
	input logic cb_host,
	input logic cb_info,
	input logic [16:0] cb_addr,
	input logic [15:0] cb_wdata,
	output logic cb_ack,
	output logic cb_retry,
	input logic jt_req,
	input ftc_op_t jt_op,
	input logic jt_info,
	input logic [16:0] jt_addr,
	input logic [15:0] jt_wdata,
	output logic jt_busy,
	output logic [15:0] rd_data,
	output logic busy,
	output logic err_prog,
	output logic err_erase,
	output logic prot_active,
	output logic core_hold_rst,
	output logic rst_ext,
	output logic fa_rd,
	output logic fa_prog,
	output logic fa_erase,
	output ftc_erg_t fa_region,
	output logic fa_info,
	output logic [16:0] fa_addr,
	output logic [15:0] fa_wdata,
	input logic [15:0] fa_rdata
);
	typedef struct packed {
		ftc_st_t st;
		ftc_ph_t ph;
		ftc_src_t src;
		logic [1:0] step;
		logic [7:0] cnt;
		logic [16:0] addr;
		logic info;
		logic [15:0] wdata;
		ftc_erg_t region;
		logic verify;
		logic busy;
		logic jt_busy;
		logic ack;
		logic retry;
		logic [15:0] rdata;
		logic err_prog;
		logic err_erase;
		logic fa_rd;
		logic fa_prog;
		logic fa_erase;
		logic rst_ext;
		logic core_hold;
		logic prot_act;
		logic jt_en_d;
		logic ini_go;
		logic tmr_start;
		logic [7:0] tmr_count;
		logic [15:0] prot;
		logic [8:0][7:0] tim;
	} ftc_ctl_t;
	ftc_ctl_t s_r, s_nxt;
	ftc_if ifc();
	logic is_op;
	logic prot_on;
	logic req_init;

	ftc_timer ftc_timer_inst (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.ifc(ifc.tmr)
	);
	ftc_init ftc_init_inst (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.ifc(ifc.ini)
	);

	assign ifc.tmr_start = s_r.tmr_start;
	assign ifc.tmr_count = s_r.tmr_count;
	assign ifc.tmr_prescale = s_r.tim[IX_PRESCALE][2:0];
	assign ifc.ini_go = s_r.ini_go;
	assign ifc.ini_clk_ok = clk_stable;
	assign is_op = (s_r.st != ST_STANDBY) && (s_r.st != ST_READ);
	assign prot_on = s_r.prot[PROT_LSB +: 2] != PROT_OPEN;
	assign req_init = (soft_rst && !jtag_en) || (jtag_en != s_r.jt_en_d);

	////////////////////////////////////////////////////////////////////////
	// launch helpers
	function automatic ftc_ctl_t start_op(ftc_ctl_t c, ftc_st_t st,
		ftc_erg_t rg, logic vf);
		ftc_ctl_t r;
		r = c;
		r.st = st;
		r.ph = PH_START;
		r.region = rg;
		r.verify = vf;
		r.step = 2'h0;
		r.busy = 1'b1;
		r.err_prog = 1'b0;
		r.err_erase = 1'b0;
		r.tmr_start = 1'b1;
		r.tmr_count = c.tim[IX_START];
		return r;
	endfunction : start_op

	function automatic ftc_ctl_t start_rd(ftc_ctl_t c, logic inf,
		logic [2:0] zw);
		ftc_ctl_t r;
		r = c;
		r.st = ST_READ;
		r.fa_rd = 1'b1;
		r.cnt = inf ? INFO_RD_CYCLES : MAIN_RD_BASE + {5'h00, zw};
		return r;
	endfunction : start_rd

	////////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		s_nxt = s_r;
		s_nxt.ack = 1'b0;
		s_nxt.retry = 1'b0;
		s_nxt.ini_go = 1'b0;
		s_nxt.tmr_start = 1'b0;
		s_nxt.jt_en_d = jtag_en;
		s_nxt.core_hold = jtag_en;
		s_nxt.prot_act = prot_on;
		if (tim_wr && (tim_sel < 4'(TIM_NUM))) begin
			s_nxt.tim[tim_sel] = tim_wdata;
		end
		if (ifc.ini_load) begin
			s_nxt.prot = fa_rdata;
			s_nxt.tim = TIM_DEFAULTS;
		end
		case (s_r.st)
			ST_STANDBY: begin
				s_nxt.busy = 1'b0;
				s_nxt.jt_busy = 1'b0;
				s_nxt.fa_rd = 1'b0;
				if (!ifc.ini_ready) begin
					s_nxt.fa_rd = ifc.ini_prot_rd;
					s_nxt.addr = PROT_WORD_ADDR;
					s_nxt.info = 1'b1;
				end else if (s_r.ini_go) begin
				end else if (jtag_en) begin
					if (jt_req && (!prot_on || jt_op == OP_SPERASE)) begin
						s_nxt.src = SRC_JTAG;
						s_nxt.addr = jt_addr;
						s_nxt.info = jt_info;
						s_nxt.wdata = jt_wdata;
						s_nxt.jt_busy = 1'b1;
						case (jt_op)
							OP_READ: s_nxt = start_rd(s_nxt, jt_info,
								zone_wait_config);
							OP_PROG: s_nxt = start_op(s_nxt, ST_PROG, ERG_PAGE,
								verify_en);
							OP_PERASE: s_nxt = start_op(s_nxt, ST_PERASE, ERG_PAGE,
								verify_en);
							OP_SERASE: s_nxt = start_op(s_nxt, ST_SERASE,
								jt_info ? ERG_SECT_BOTH : ERG_SECT_MAIN, 1'b1);
							default: s_nxt = start_op(s_nxt, ST_SPERASE,
								ERG_ALL_MAIN, 1'b1);
						endcase
					end
				end else if ((cb_rd || cb_wr) && !s_r.ack) begin
					s_nxt.src = cb_host ? SRC_HOST : SRC_CORE;
					s_nxt.addr = cb_addr;
					s_nxt.info = cb_info;
					s_nxt.wdata = cb_wdata;
					if (cb_rd) begin
						s_nxt = start_rd(s_nxt, cb_info, zone_wait_config);
					end else begin
						s_nxt.ack = 1'b1;
						if (prog_en) begin
							s_nxt = start_op(s_nxt, ST_PROG, ERG_PAGE, verify_en);
						end else if (page_erase_en) begin
							s_nxt = start_op(s_nxt, ST_PERASE, ERG_PAGE,
								verify_en);
						end else if (section_erase_en && !cb_host) begin
							s_nxt = start_op(s_nxt, ST_SERASE,
								cb_info ? ERG_SECT_BOTH : ERG_SECT_MAIN, 1'b1);
						end
					end
				end
			end
			ST_READ: begin
				if (soft_rst) begin
					s_nxt.st = ST_STANDBY;
					s_nxt.fa_rd = 1'b0;
					s_nxt.jt_busy = 1'b0;
				end else if (s_r.cnt <= 8'h01) begin
					s_nxt.st = ST_STANDBY;
					s_nxt.fa_rd = 1'b0;
					s_nxt.rdata = fa_rdata;
					s_nxt.ack = s_r.src != SRC_JTAG;
					s_nxt.jt_busy = 1'b0;
				end else begin
					s_nxt.cnt = s_r.cnt - 8'h01;
				end
			end
			default: begin
				if (s_r.ph == PH_VERIFY) begin
					if (s_r.cnt <= 8'h01) begin
						s_nxt.fa_rd = 1'b0;
						if (s_r.st == ST_PROG) begin
							s_nxt.err_prog = fa_rdata != s_r.wdata;
						end else begin
							s_nxt.err_erase = fa_rdata != ERASED_WORD;
						end
						s_nxt.st = ST_STANDBY;
						s_nxt.busy = 1'b0;
						s_nxt.jt_busy = 1'b0;
					end else begin
						s_nxt.cnt = s_r.cnt - 8'h01;
					end
				end else if (ifc.tmr_done) begin
					s_nxt.tmr_start = 1'b1;
					case (s_r.ph)
						PH_START: begin
							s_nxt.ph = PH_PULSE;
							s_nxt.fa_prog = s_r.st == ST_PROG;
							s_nxt.fa_erase = s_r.st != ST_PROG;
							if (s_r.st == ST_PROG) begin
								s_nxt.tmr_count = s_r.tim[IX_PROG];
							end else if (s_r.st == ST_PERASE) begin
								s_nxt.tmr_count = s_r.tim[IX_PERASE];
							end else begin
								s_nxt.tmr_count = s_r.tim[IX_SERASE];
							end
						end
						PH_PULSE: begin
							s_nxt.ph = PH_END;
							s_nxt.fa_prog = 1'b0;
							s_nxt.fa_erase = 1'b0;
							s_nxt.tmr_count = (s_r.st == ST_SERASE ||
								s_r.st == ST_SPERASE) ? s_r.tim[IX_SEND] :
								s_r.tim[IX_END];
						end
						PH_END: begin
							s_nxt.ph = PH_RCV;
							s_nxt.tmr_count = s_r.tim[IX_RCV];
						end
						PH_TRAN: begin
							s_nxt.ph = PH_PULSE;
							s_nxt.fa_erase = 1'b1;
							s_nxt.tmr_count = s_r.tim[IX_SERASE];
						end
						default: begin
							s_nxt.tmr_start = 1'b0;
							if (s_r.st == ST_SPERASE && s_r.step != 2'h2) begin
								s_nxt.ph = PH_TRAN;
								s_nxt.tmr_start = 1'b1;
								s_nxt.tmr_count = s_r.tim[IX_TRAN];
								s_nxt.step = s_r.step + 2'h1;
								s_nxt.region = (s_r.step == 2'h0) ?
									ERG_INFO_NOFACT : ERG_PROT;
							end else if (s_r.verify) begin
								s_nxt.ph = PH_VERIFY;
								s_nxt.fa_rd = 1'b1;
								s_nxt.cnt = INFO_RD_CYCLES;
							end else begin
								s_nxt.st = ST_STANDBY;
								s_nxt.busy = 1'b0;
								s_nxt.jt_busy = 1'b0;
							end
						end
					endcase
				end
				if ((cb_rd || cb_wr) && !s_r.ack && !jtag_en) begin
					if (cb_host) begin
						s_nxt.ack = 1'b1;
						s_nxt.retry = 1'b1;
					end else if (cb_wr) begin
						s_nxt.ack = 1'b1;
					end
				end
			end
		endcase
		if ((req_init || s_r.rst_ext) &&
			(s_nxt.st inside {ST_STANDBY, ST_READ})) begin
			s_nxt.ini_go = 1'b1;
			s_nxt.rst_ext = 1'b0;
			s_nxt.st = ST_STANDBY;
			s_nxt.fa_rd = 1'b0;
			s_nxt.jt_busy = 1'b0;
		end else if (req_init) begin
			s_nxt.rst_ext = 1'b1;
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			s_r <= '0;
			s_r.tim <= TIM_DEFAULTS;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign cb_ack = s_r.ack;
	assign cb_retry = s_r.retry;
	assign jt_busy = s_r.jt_busy;
	assign rd_data = s_r.rdata;
	assign busy = s_r.busy;
	assign err_prog = s_r.err_prog;
	assign err_erase = s_r.err_erase;
	assign prot_active = s_r.prot_act;
	assign core_hold_rst = s_r.core_hold;
	assign rst_ext = s_r.rst_ext;
	assign fa_rd = s_r.fa_rd;
	assign fa_prog = s_r.fa_prog;
	assign fa_erase = s_r.fa_erase;
	assign fa_region = s_r.region;
	assign fa_info = s_r.info;
	assign fa_addr = s_r.addr;
	assign fa_wdata = s_r.wdata;

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb_clk @(posedge mclk); endclocking
	default disable iff (sys_rst);

	sequence seq_info_launch;
		s_r.st == ST_STANDBY && s_nxt.st == ST_READ && s_nxt.info;
	endsequence
	sequence seq_quiet3;
		(!soft_rst && !req_init)[*3];
	endsequence

	property p_info_rd;
		seq_info_launch ##1 seq_quiet3 |=> s_r.st == ST_STANDBY;
	endproperty
	a_info_rd: assert property (p_info_rd)
		else $error("info read not 3 cycles");

	property p_rd_abort;
		s_r.st == ST_READ && soft_rst |=> s_r.st == ST_STANDBY && !cb_ack;
	endproperty
	a_rd_abort: assert property (p_rd_abort)
		else $error("read not aborted");

	property p_busy_op;
		is_op |-> busy;
	endproperty
	a_busy_op: assert property (p_busy_op)
		else $error("busy low in op");

	property p_rst_stretch;
		is_op && soft_rst && !jtag_en && s_nxt.st != ST_STANDBY |=> rst_ext;
	endproperty
	a_rst_stretch: assert property (p_rst_stretch)
		else $error("no reset stretch");

	property p_host_retry;
		is_op && cb_host && (cb_rd || cb_wr) && !cb_ack && !jtag_en
			|=> cb_retry && cb_ack;
	endproperty
	a_host_retry: assert property (p_host_retry)
		else $error("host not refused");

	property p_core_rd_held;
		is_op && cb_rd && !cb_wr && !cb_host |=> !cb_ack;
	endproperty
	a_core_rd_held: assert property (p_core_rd_held)
		else $error("read served");

	property p_no_host_sect;
		s_r.st == ST_STANDBY && ifc.ini_ready && !jtag_en && cb_wr && cb_host
			&& !prog_en && !page_erase_en && !cb_ack |=> s_r.st != ST_SERASE;
	endproperty
	a_no_host_sect: assert property (p_no_host_sect)
		else $error("host sect");

	property p_core_hold;
		jtag_en |=> core_hold_rst;
	endproperty
	a_core_hold: assert property (p_core_hold)
		else $error("core not held");

	property p_busy_fall;
		$fell(busy) |-> s_r.st == ST_STANDBY;
	endproperty
	a_busy_fall: assert property (p_busy_fall)
		else $error("busy fell early");

	property p_prot_last;
		s_r.st == ST_SPERASE && fa_erase && fa_region == ERG_PROT
			|-> s_r.step == 2'h2;
	endproperty
	a_prot_last: assert property (p_prot_last)
		else $error("prot not last");

	property p_defaults;
		ifc.ini_load |=> s_r.tim[IX_START] == DEF_START
			&& s_r.tim[IX_SEND] == DEF_SEND;
	endproperty
	a_defaults: assert property (p_defaults)
		else $error("no defaults");
endmodule : ftc_ctrl

/* File: src/ftc_init.sv */
`timescale 1ns/1ns
module ftc_init import ftc_pkg::*; (
	input logic mclk,
	input logic sys_rst,
	ftc_if.ini ifc
);
	typedef enum logic [1:0] {I_CLK, I_PROT, I_LOAD, I_DONE} ftc_ist_t;
	typedef struct packed {
		ftc_ist_t st;
		logic [7:0] cnt;
		logic prot_rd;
		logic load;
		logic ready;
	} ftc_ini_t;
	ftc_ini_t s_r, s_nxt;

	////////////////////////////////////////////////////////////////////////
	// clocks stable, protection word read, defaults loaded
	always_comb begin
		s_nxt = s_r;
		s_nxt.load = 1'b0;
		case (s_r.st)
			I_CLK: begin
				if (ifc.ini_clk_ok) begin
					s_nxt.st = I_PROT;
					s_nxt.prot_rd = 1'b1;
					s_nxt.cnt = INFO_RD_CYCLES;
				end
			end
			I_PROT: begin
				if (s_r.cnt <= 8'h01) begin
					s_nxt.st = I_LOAD;
					s_nxt.prot_rd = 1'b0;
					s_nxt.load = 1'b1;
				end else begin
					s_nxt.cnt = s_r.cnt - 8'h01;
				end
			end
			I_LOAD: begin
				s_nxt.st = I_DONE;
				s_nxt.ready = 1'b1;
			end
			default: begin
			end
		endcase
		if (ifc.ini_go) begin
			s_nxt = '0;
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign ifc.ini_prot_rd = s_r.prot_rd;
	assign ifc.ini_load = s_r.load;
	assign ifc.ini_ready = s_r.ready;
endmodule : ftc_init

/* File: src/ftc_timer.sv */
`timescale 1ns/1ns
module ftc_timer import ftc_pkg::*; (
	input logic mclk,
	input logic sys_rst,
	ftc_if.tmr ifc
);
	typedef struct packed {
		logic run;
		logic [2:0] pre;
		logic [7:0] cnt;
		logic done;
	} ftc_tmr_t;
	ftc_tmr_t s_r, s_nxt;

	////////////////////////////////////////////////////////////////////////
	// prescaled down-counter, one done pulse
	always_comb begin
		s_nxt = s_r;
		s_nxt.done = 1'b0;
		if (ifc.tmr_start) begin
			s_nxt.run = 1'b1;
			s_nxt.pre = ifc.tmr_prescale;
			s_nxt.cnt = ifc.tmr_count;
		end else if (s_r.run) begin
			if (s_r.pre != 3'h0) begin
				s_nxt.pre = s_r.pre - 3'h1;
			end else begin
				s_nxt.pre = ifc.tmr_prescale;
				if (s_r.cnt <= 8'h01) begin
					s_nxt.run = 1'b0;
					s_nxt.done = 1'b1;
				end else begin
					s_nxt.cnt = s_r.cnt - 8'h01;
				end
			end
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign ifc.tmr_done = s_r.done;
endmodule : ftc_timer
